// File: pkg/eac_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the EEPROM access block
// Assumes: Data-space offsets; the in/out view sits EAC_IO_BIAS lower
// Notes:   Definitions only
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH

// Register offsets in data space
`define EAC_CTRL_OFF   8'h3f
`define EAC_DATA_OFF   8'h40
`define EAC_ADRL_OFF   8'h41
`define EAC_ADRH_OFF   8'h42
`define EAC_IO_BIAS    8'h20

// Reset values
`define EAC_CTRL_RST   8'h00
`define EAC_DATA_RST   8'h00
`define EAC_ADDR_RST   11'h000

// Control register field positions
`define EAC_PM_HI      5
`define EAC_PM_LO      4
`define EAC_RIE_BIT    3
`define EAC_ARM_BIT    2
`define EAC_WS_BIT     1
`define EAC_RS_BIT     0

// Core-clock cycle counts
`define EAC_ARM_CYCLES 3'h4
`define EAC_RD_STALL   3'h4
`define EAC_WR_STALL   3'h2

// Programming times in RC oscillator cycles and in milliseconds
`define EAC_ATOMIC_RC  26368
`define EAC_SPLIT_RC   13184
`define EAC_ATOMIC_MS  3.4
`define EAC_SPLIT_MS   1.8

// Array geometry and erased value
`define EAC_ADDR_BITS  11
`define EAC_DEPTH      2048
`define EAC_ERASED     8'hff

`endif

// File: pkg/eac_pkg.sv
// Purpose: Types shared by the EEPROM access block
// Assumes: Constants come from eac_defs.svh
// Notes:   Mode codes follow the program-action field
package eac_pkg;

    typedef logic [7:0] eac_byte_t;

    // Program-action field codes
    typedef enum logic [1:0] {
        EAC_PM_ATOMIC = 2'h0,
        EAC_PM_ERASE  = 2'h1,
        EAC_PM_WRITE  = 2'h2,
        EAC_PM_RSVD   = 2'h3
    } eac_mode_e;

    // Programming timer states, one-hot
    typedef enum logic [1:0] {
        EAC_T_IDLE = 2'h1,
        EAC_T_RUN  = 2'h2
    } eac_tstate_e;

endpackage

// File: rtl/eac_nvm_array.sv
// Purpose: Byte-wide nonvolatile array model with erase, write and atomic update
// Assumes: Update is applied in the cycle the programming timer finishes
// Notes:   Write-only can clear bits but never set them, as on a real cell
`timescale 1ns/1ps
`include "eac_defs.svh"
module eac_nvm_array #(
    parameter int DEPTH  = `EAC_DEPTH,
    parameter int ADDR_W = `EAC_ADDR_BITS
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Read port
    input  wire logic                rdEn,
    input  wire logic [ADDR_W-1:0]   rdAddr,
    output eac_pkg::eac_byte_t       rdData,
    // Programming port
    input  wire logic                progEn,
    input  wire eac_pkg::eac_mode_e  progMode,
    input  wire logic [ADDR_W-1:0]   progAddr,
    input  wire eac_pkg::eac_byte_t  progData
);
    import eac_pkg::*;

    generate
        if (DEPTH > (1 << ADDR_W)) begin : g_bad
            $error("eac_nvm_array: DEPTH exceeds address range");
        end
    endgenerate

    eac_byte_t mem [DEPTH];

    // Cell update at the end of a programming run
    always_ff @(posedge clk) begin
        if (progEn) begin
            unique case (progMode)
                EAC_PM_ATOMIC: mem[progAddr] <= progData;
                EAC_PM_ERASE:  mem[progAddr] <= `EAC_ERASED;
                EAC_PM_WRITE:  mem[progAddr] <= mem[progAddr] & progData;
                EAC_PM_RSVD:   mem[progAddr] <= mem[progAddr];
            endcase
        end
    end

    // Registered read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// File: rtl/eac_prog_timer.sv
// Purpose: Times one programming run from the calibrated RC oscillator
// Assumes: rcOscPin is asynchronous to clk and much slower than it
// Notes:   A run in progress ignores reset, so an update survives a system reset
`timescale 1ns/1ps
`include "eac_defs.svh"
module eac_prog_timer #(
    parameter int ATOMIC_RC = `EAC_ATOMIC_RC,
    parameter int SPLIT_RC  = `EAC_SPLIT_RC
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Oscillator pin
    input  wire logic                rcOscPin,
    // Control
    input  wire logic                start,
    input  wire eac_pkg::eac_mode_e  mode,
    output logic                     busy,
    output logic                     done
);
    import eac_pkg::*;

    localparam int CW = 15;

    generate
        if (ATOMIC_RC < 1 || SPLIT_RC < 1 || ATOMIC_RC > (1 << CW) || SPLIT_RC > (1 << CW)) begin : g_bad
            $error("eac_prog_timer: RC counts out of range");
        end
    endgenerate

    logic              rcMeta;
    logic              rcSync;
    logic              rcPrev;
    logic              rcEdge;
    logic [CW-1:0]     count;
    eac_tstate_e       state;

    // Two-stage synchroniser and edge detect on the second stage only;
    // left running through a reset mid-run so no false edge shortens the run
    always_ff @(posedge clk) begin
        if (rst && state != EAC_T_RUN) begin
            rcMeta <= 1'b0;
            rcSync <= 1'b0;
            rcPrev <= 1'b0;
        end else begin
            rcMeta <= rcOscPin;
            rcSync <= rcMeta;
            rcPrev <= rcSync;
        end
    end

    assign rcEdge = rcSync & ~rcPrev;

    // Run counter; reset is honoured only while idle
    always_ff @(posedge clk) begin
        if (rst && state != EAC_T_RUN) begin
            state <= EAC_T_IDLE;
            count <= '0;
        end else begin
            unique case (state)
                EAC_T_IDLE: begin
                    if (start) begin
                        state <= EAC_T_RUN;
                        count <= (mode == EAC_PM_ATOMIC) ? CW'(ATOMIC_RC - 1) : CW'(SPLIT_RC - 1);
                    end
                end
                EAC_T_RUN: begin
                    if (rcEdge) begin
                        if (count == '0) begin
                            state <= EAC_T_IDLE;
                        end else begin
                            count <= count - 1'b1;
                        end
                    end
                end
                default: state <= EAC_T_IDLE;
            endcase
        end
    end

    assign busy = (state == EAC_T_RUN);

    // Last edge of a run; the cell update and the busy drop share this edge,
    // so a read strobe seen right after busy falls always gets the new byte
    assign done = (state == EAC_T_RUN) && rcEdge && (count == '0);

endmodule

// File: rtl/eac_top.sv
// Purpose: EEPROM access control seen by the core: address, data and control registers
// Assumes: Core bus on clk; flash self-programming busy and global enable come from core logic
// Notes:   Programming is timed by the RC oscillator and survives a system reset
`timescale 1ns/1ps
`include "eac_defs.svh"

// Behaviour
// - Control: action bits 5:4, ready enable 3, arm 2, write strobe 1, read strobe 0.
// - Action 00 erase+write, 01 erase, 10 write, 11 reserved and never started.
// - Action field writes are dropped while the write strobe bit is set.
// - Reset clears the action field unless programming is still running.
// - Ready request stays high while enabled, globally enabled and strobe bit clear.
// - No ready request during EEPROM programming or flash self-programming.
// - Arm bit clears by itself four cycles after software sets it.
// - Strobe starts programming only while arm is still one.
// - Strobe written with arm zero does nothing.
// - No EEPROM programming starts while flash self-programming is busy.
// - Hardware clears the write strobe bit when programming time ends.
// - Starting a write halts the core for two cycles.
// - Read strobe loads the addressed byte into the data register one cycle later.
// - A read strobe halts the core for four cycles.
// - While programming, reads are refused and the address is frozen.
// - Atomic programming lasts 26368 RC oscillator cycles.
// - Data register feeds writes and receives read results.
// - Registers decode at data offsets, and 0x20 lower for in/out accesses.
// - Eleven-bit byte address, upper bits of the high byte read zero.
module eac_top #(
    parameter int ATOMIC_RC = `EAC_ATOMIC_RC,
    parameter int SPLIT_RC  = `EAC_SPLIT_RC,
    parameter int ADDR_W    = `EAC_ADDR_BITS,
    parameter int DEPTH     = `EAC_DEPTH
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Core register port
    input  wire logic [7:0]          ioAddr,
    input  wire logic                ioDataSpace,
    input  wire logic                ioWrite,
    input  wire logic                ioRead,
    input  wire eac_pkg::eac_byte_t  ioWdata,
    output eac_pkg::eac_byte_t       ioRdata,
    // Core status inputs
    input  wire logic                globalIntEnable,
    input  wire logic                flashSelfprogBusy,
    // Oscillator pin
    input  wire logic                rcOscPin,
    // Outputs to the core
    output logic                     cpuHalt,
    output logic                     readyIrq,
    output logic                     eepromBusy
);
    import eac_pkg::*;

    generate
        if (ADDR_W != `EAC_ADDR_BITS || DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_bad
            $error("eac_top: address width or depth unsupported");
        end
    endgenerate

    // Register hit in either addressing view
    function automatic logic regHit(input logic [7:0] addr, input logic dataSpace, input logic [7:0] off);
        regHit = dataSpace ? (addr == off) : (addr == off - `EAC_IO_BIAS);
    endfunction

    // Control register state
    eac_mode_e              programActionField;
    logic                   readyInterruptEnable;
    logic                   writeArm;
    logic [2:0]             armCount;
    // Data and address registers
    eac_byte_t              eepromData;
    logic [ADDR_W-1:0]      eepromByteAddress;
    // Captured programming request
    eac_mode_e              progMode;
    logic [ADDR_W-1:0]      progAddr;
    eac_byte_t              progData;
    // Read path
    logic                   readPending;
    eac_byte_t              arrayRdData;
    // Halt counter
    logic [2:0]             haltCount;
    // Timer
    logic                   timerBusy;
    logic                   timerDone;
    // Decode
    logic                   ctrlWr;
    logic                   dataWr;
    logic                   adrlWr;
    logic                   adrhWr;
    logic                   startWrite;
    logic                   startRead;
    eac_mode_e              reqMode;
    eac_byte_t              ctrlView;
    logic [15:0]            addrView;

    assign ctrlWr = ioWrite & regHit(ioAddr, ioDataSpace, `EAC_CTRL_OFF);
    assign dataWr = ioWrite & regHit(ioAddr, ioDataSpace, `EAC_DATA_OFF);
    assign adrlWr = ioWrite & regHit(ioAddr, ioDataSpace, `EAC_ADRL_OFF);
    assign adrhWr = ioWrite & regHit(ioAddr, ioDataSpace, `EAC_ADRH_OFF);

    // Mode for a strobe: the value in the same store when the field is writable
    assign reqMode = eac_mode_e'(ioWdata[`EAC_PM_HI:`EAC_PM_LO]);

    // Write start needs the arm still open, no run, no flash update, a defined mode
    assign startWrite = ~rst & ctrlWr & ioWdata[`EAC_WS_BIT]
                      & writeArm
                      & ~timerBusy
                      & ~flashSelfprogBusy
                      & (reqMode != EAC_PM_RSVD);

    // Reads are refused while programming runs
    assign startRead = ~rst & ctrlWr & ioWdata[`EAC_RS_BIT] & ~timerBusy;

    // Program-action field: dropped while busy, kept over reset while busy
    always_ff @(posedge clk) begin
        if (rst) begin
            if (!timerBusy) begin
                programActionField <= EAC_PM_ATOMIC;
            end
        end else if (ctrlWr && !timerBusy) begin
            programActionField <= reqMode;
        end
    end

    // Ready interrupt enable
    always_ff @(posedge clk) begin
        if (rst) begin
            readyInterruptEnable <= 1'b0;
        end else if (ctrlWr) begin
            readyInterruptEnable <= ioWdata[`EAC_RIE_BIT];
        end
    end

    // Arm bit with its self-clearing window
    always_ff @(posedge clk) begin
        if (rst) begin
            writeArm <= 1'b0;
            armCount <= 3'h0;
        end else if (ctrlWr && ioWdata[`EAC_ARM_BIT]) begin
            writeArm <= 1'b1;
            armCount <= `EAC_ARM_CYCLES - 3'h1;
        end else if (ctrlWr) begin
            writeArm <= 1'b0;
            armCount <= 3'h0;
        end else if (armCount != 3'h0) begin
            armCount <= armCount - 3'h1;
        end else begin
            writeArm <= 1'b0;
        end
    end

    // Address register; frozen while a run is in progress
    always_ff @(posedge clk) begin
        if (rst) begin
            eepromByteAddress <= `EAC_ADDR_RST;
        end else if (!timerBusy) begin
            if (adrlWr) begin
                eepromByteAddress[7:0] <= ioWdata;
            end
            if (adrhWr) begin
                eepromByteAddress[ADDR_W-1:8] <= ioWdata[ADDR_W-9:0];
            end
        end
    end

    // Data register: read result wins over a store in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            eepromData <= `EAC_DATA_RST;
        end else if (readPending) begin
            eepromData <= arrayRdData;
        end else if (dataWr) begin
            eepromData <= ioWdata;
        end
    end

    // Read result lands one cycle after the strobe, well inside the halt
    always_ff @(posedge clk) begin
        if (rst) begin
            readPending <= 1'b0;
        end else begin
            readPending <= startRead;
        end
    end

    // Capture the request so later stores to the data register cannot corrupt it
    always_ff @(posedge clk) begin
        if (rst) begin
            if (!timerBusy) begin
                progMode <= EAC_PM_ATOMIC;
                progAddr <= `EAC_ADDR_RST;
                progData <= `EAC_DATA_RST;
            end
        end else if (startWrite) begin
            progMode <= reqMode;
            progAddr <= eepromByteAddress;
            progData <= eepromData;
        end
    end

    // Core halt: four cycles for a read, two for a started write
    always_ff @(posedge clk) begin
        if (rst) begin
            cpuHalt   <= 1'b0;
            haltCount <= 3'h0;
        end else if (startRead) begin
            cpuHalt   <= 1'b1;
            haltCount <= `EAC_RD_STALL - 3'h1;
        end else if (startWrite) begin
            cpuHalt   <= 1'b1;
            haltCount <= `EAC_WR_STALL - 3'h1;
        end else if (haltCount != 3'h0) begin
            haltCount <= haltCount - 3'h1;
        end else begin
            cpuHalt <= 1'b0;
        end
    end

    // Ready request is a level, not a pulse; it holds while the engine is idle
    always_ff @(posedge clk) begin
        if (rst) begin
            readyIrq <= 1'b0;
        end else begin
            readyIrq <= readyInterruptEnable & globalIntEnable
                      & ~timerBusy & ~startWrite & ~flashSelfprogBusy;
        end
    end

    // Busy status mirrors the write strobe bit
    always_ff @(posedge clk) begin
        if (rst && !timerBusy) begin
            eepromBusy <= 1'b0;
        end else begin
            eepromBusy <= startWrite | (timerBusy & ~timerDone);
        end
    end

    // Register read views; unused bits read zero
    always_comb begin
        ctrlView = 8'h00;
        ctrlView[`EAC_PM_HI:`EAC_PM_LO] = programActionField;
        ctrlView[`EAC_RIE_BIT] = readyInterruptEnable;
        ctrlView[`EAC_ARM_BIT] = writeArm;
        ctrlView[`EAC_WS_BIT]  = timerBusy;
        addrView = 16'h0000;
        addrView[ADDR_W-1:0] = eepromByteAddress;
    end

    // Registered read data; an unmapped address returns zero
    always_ff @(posedge clk) begin
        if (rst) begin
            ioRdata <= 8'h00;
        end else if (ioRead) begin
            if (regHit(ioAddr, ioDataSpace, `EAC_CTRL_OFF)) begin
                ioRdata <= ctrlView;
            end else if (regHit(ioAddr, ioDataSpace, `EAC_DATA_OFF)) begin
                ioRdata <= eepromData;
            end else if (regHit(ioAddr, ioDataSpace, `EAC_ADRL_OFF)) begin
                ioRdata <= addrView[7:0];
            end else if (regHit(ioAddr, ioDataSpace, `EAC_ADRH_OFF)) begin
                ioRdata <= addrView[15:8];
            end else begin
                ioRdata <= 8'h00;
            end
        end
    end

    // Programming timer on the RC oscillator
    eac_prog_timer #(
        .ATOMIC_RC (ATOMIC_RC),
        .SPLIT_RC  (SPLIT_RC)
    ) u_timer (
        .clk      (clk),
        .rst      (rst),
        .rcOscPin (rcOscPin),
        .start    (startWrite),
        .mode     (reqMode),
        .busy     (timerBusy),
        .done     (timerDone)
    );

    // Cell array; the update lands when the timer finishes
    eac_nvm_array #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W)
    ) u_array (
        .clk      (clk),
        .rst      (rst),
        .rdEn     (startRead),
        .rdAddr   (eepromByteAddress),
        .rdData   (arrayRdData),
        .progEn   (timerDone),
        .progMode (progMode),
        .progAddr (progAddr),
        .progData (progData)
    );

endmodule

// File: test/eac_top_chk.sv
// Purpose: Port-level assertions for the EEPROM access block
// Assumes: Offsets and field positions come from eac_defs.svh
// Notes:   Bound to eac_top at the foot of this file
`timescale 1ns/1ps
`include "eac_defs.svh"
module eac_top_chk (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Core register port
    input  wire logic [7:0]          ioAddr,
    input  wire logic                ioDataSpace,
    input  wire logic                ioWrite,
    input  wire logic                ioRead,
    input  wire eac_pkg::eac_byte_t  ioWdata,
    input  wire eac_pkg::eac_byte_t  ioRdata,
    // Core status and outputs
    input  wire logic                globalIntEnable,
    input  wire logic                flashSelfprogBusy,
    input  wire logic                cpuHalt,
    input  wire logic                readyIrq,
    input  wire logic                eepromBusy
);
    import eac_pkg::*;
    logic [7:0] dsAddr;
    logic       ctrlSel;
    logic       anySel;

    // Fold the in/out view onto data-space offsets so one decode serves both
    assign dsAddr  = ioDataSpace ? ioAddr : ioAddr + `EAC_IO_BIAS;
    assign ctrlSel = (dsAddr == `EAC_CTRL_OFF);
    assign anySel  = ctrlSel || dsAddr == `EAC_DATA_OFF || dsAddr == `EAC_ADRL_OFF || dsAddr == `EAC_ADRH_OFF;

    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);

    a_read_halt_four: assert property (
        ioWrite && ctrlSel && ioWdata[0] && !ioWdata[1] && !eepromBusy |=> cpuHalt [*4] ##1 !cpuHalt)
        else $error("read strobe halt length wrong");
    a_write_halt_two: assert property (
        $rose(eepromBusy) |-> cpuHalt ##1 cpuHalt ##1 !cpuHalt)
        else $error("write start halt length wrong");
    a_start_cause: assert property (
        $rose(eepromBusy) |-> $past(ioWrite && ctrlSel && ioWdata[1] && !flashSelfprogBusy))
        else $error("programming started without a valid strobe");
    a_irq_gated: assert property (
        readyIrq |-> $past(globalIntEnable && !flashSelfprogBusy))
        else $error("ready request without global enable or with flash busy");
    a_irq_not_busy: assert property (
        eepromBusy && $past(eepromBusy) |-> !readyIrq)
        else $error("ready request during programming");
    // Only a control store can drop enable or start a run, so the level must hold otherwise
    a_irq_holds: assert property (
        readyIrq && globalIntEnable && !flashSelfprogBusy && !(ioWrite && ctrlSel)
        && !$past(ioWrite && ctrlSel) |=> readyIrq)
        else $error("ready request dropped while idle");
    a_unmapped_zero: assert property (
        ioRead && !anySel |=> ioRdata == 8'h00)
        else $error("unmapped load returned nonzero");
    a_ctrl_top_zero: assert property (
        ioRead && ctrlSel |=> ioRdata[7:6] == 2'h0)
        else $error("unused control bits read nonzero");
    a_busy_no_halt: assert property (
        eepromBusy && $past(eepromBusy, 3) && ioWrite && ctrlSel |=> !cpuHalt)
        else $error("strobe accepted while programming");
endmodule

bind eac_top eac_top_chk u_chk (
    .clk              (clk),
    .rst              (rst),
    .ioAddr           (ioAddr),
    .ioDataSpace      (ioDataSpace),
    .ioWrite          (ioWrite),
    .ioRead           (ioRead),
    .ioWdata          (ioWdata),
    .ioRdata          (ioRdata),
    .globalIntEnable  (globalIntEnable),
    .flashSelfprogBusy(flashSelfprogBusy),
    .cpuHalt          (cpuHalt),
    .readyIrq         (readyIrq),
    .eepromBusy       (eepromBusy)
);

// File: test/eac_top_test.sv
// Purpose: Self-checking bench for the EEPROM access block
// Assumes: Short programming counts; RC pin toggles every other core clock
// Notes:   Register accesses go through the core register port, as software would; status pins are driven and sampled directly
`timescale 1ns/1ps
`include "eac_defs.svh"
module eac_top_test;
    import eac_pkg::*;
    logic       clk, rst, ioDataSpace, ioWrite, ioRead;
    logic       globalIntEnable, flashSelfprogBusy, rcOscPin;
    logic       cpuHalt, readyIrq, eepromBusy;
    logic [7:0] ioAddr;
    eac_byte_t  ioWdata, ioRdata, got;
    int         n_mismatch, comparisons;
    // Erase, write-only twice (bits only clear), then the reserved code
    logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
    eac_byte_t  dats  [4] = '{8'h00, 8'h3c, 8'hf0, 8'h55};
    eac_byte_t  exps  [4] = '{8'hff, 8'h3c, 8'h30, 8'h30};

    eac_top #(.ATOMIC_RC(8), .SPLIT_RC(4)) dut (
        .clk(clk), .rst(rst), .ioAddr(ioAddr), .ioDataSpace(ioDataSpace), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .globalIntEnable(globalIntEnable),
        .flashSelfprogBusy(flashSelfprogBusy), .rcOscPin(rcOscPin), .cpuHalt(cpuHalt),
        .readyIrq(readyIrq), .eepromBusy(eepromBusy));

    // Core clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Slow RC oscillator so the two-flop synchroniser sees every level
    initial begin
        rcOscPin = 1'b0;
        forever begin
            repeat (2) @(posedge clk);
            #1 rcOscPin = ~rcOscPin;
        end
    end

    task automatic check(input eac_byte_t g, input eac_byte_t e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One store, held over the edge that takes it
    task automatic wr(input logic [7:0] a, input eac_byte_t d);
        @(posedge clk);
        #1;
        ioAddr = a;
        ioWdata = d;
        ioWrite = 1'b1;
        @(posedge clk);
        #1;
        ioWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output eac_byte_t d);
        @(posedge clk);
        #1;
        ioAddr = a;
        ioRead = 1'b1;
        @(posedge clk);
        #1;
        ioRead = 1'b0;
        d = ioRdata;
    endtask
    // Bounded wait for the end of halt and programming
    task automatic waitIdle();
        int i;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while ((eepromBusy !== 1'b0 || cpuHalt !== 1'b0) && i < 300);
        if (i >= 300) check(8'h00, 8'h01);
    endtask
    // Load address and data, arm, then strobe two cycles later
    task automatic prog(input logic [1:0] m, input logic ie, input logic [10:0] a, input eac_byte_t d);
        wr(8'h41, a[7:0]);
        wr(8'h42, {5'h00, a[10:8]});
        wr(8'h40, d);
        wr(8'h3f, {2'h0, m, ie, 3'h4});
        wr(8'h3f, {2'h0, m, ie, 3'h2});
    endtask
    task automatic rdByte(input logic [10:0] a, output eac_byte_t d);
        wr(8'h41, a[7:0]);
        wr(8'h42, {5'h00, a[10:8]});
        wr(8'h3f, 8'h01);
        check({7'h00, cpuHalt}, 8'h01);
        waitIdle();
        rd(8'h40, d);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Cut a hang well beyond the expected run of a few hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {ioDataSpace, rst} = 2'b11;
        {ioWrite, ioRead, globalIntEnable, flashSelfprogBusy} = 4'h0;
        ioAddr = 8'h00;
        ioWdata = 8'h00;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        // Reset values, both views, address width, unused and unmapped places
        rd(8'h3f, got); check(got, 8'h00);
        rd(8'h40, got); check(got, 8'h00);
        ioDataSpace = 1'b0;
        wr(8'h20, 8'h5a);
        ioDataSpace = 1'b1;
        rd(8'h40, got); check(got, 8'h5a);
        wr(8'h41, 8'hff);
        wr(8'h42, 8'hff);
        rd(8'h42, got); check(got, 8'h07);
        wr(8'h3f, 8'hc8);
        ioDataSpace = 1'b0;
        rd(8'h1f, got); check(got, 8'h08);
        ioDataSpace = 1'b1;
        wr(8'h43, 8'h11);
        rd(8'h43, got); check(got, 8'h00);
        // Arm reads back, times out, and a late strobe starts nothing
        wr(8'h3f, 8'h04);
        rd(8'h3f, got); check(got, 8'h04);
        @(posedge clk);
        rd(8'h3f, got); check(got, 8'h00);
        wr(8'h3f, 8'h02);
        @(posedge clk);
        #1 check({7'h00, eepromBusy}, 8'h00);
        // Atomic write at the top address; refusals while it runs
        prog(2'h0, 1'b0, 11'h7ff, 8'ha5);
        wr(8'h41, 8'h00);
        wr(8'h3f, 8'h10);
        wr(8'h3f, 8'h01);
        rd(8'h41, got); check(got, 8'hff);
        rd(8'h3f, got); check(got & 8'h32, 8'h02);
        rd(8'h40, got); check(got, 8'ha5);
        waitIdle();
        rd(8'h3f, got); check(got & 8'h02, 8'h00);
        rdByte(11'h7ff, got); check(got, 8'ha5);
        for (int i = 0; i < 4; i++) begin
            prog(modes[i], 1'b0, 11'h123, dats[i]);
            waitIdle();
            rdByte(11'h123, got); check(got, exps[i]);
        end
        // Flash self-programming blocks a start
        flashSelfprogBusy = 1'b1;
        prog(2'h1, 1'b0, 11'h123, 8'h00);
        @(posedge clk);
        #1 check({7'h00, eepromBusy}, 8'h00);
        flashSelfprogBusy = 1'b0;
        rdByte(11'h123, got); check(got, 8'h30);
        // Ready request: level while idle, gated by flash, programming and global flag
        globalIntEnable = 1'b1;
        wr(8'h3f, 8'h08);
        repeat (3) @(posedge clk);
        #1 check({7'h00, readyIrq}, 8'h01);
        flashSelfprogBusy = 1'b1;
        repeat (2) @(posedge clk);
        #1 check({7'h00, readyIrq}, 8'h00);
        flashSelfprogBusy = 1'b0;
        prog(2'h2, 1'b1, 11'h123, 8'hff);
        @(posedge clk);
        #1 check({7'h00, readyIrq}, 8'h00);
        waitIdle();
        @(posedge clk);
        #1 check({7'h00, readyIrq}, 8'h01);
        globalIntEnable = 1'b0;
        repeat (2) @(posedge clk);
        #1 check({7'h00, readyIrq}, 8'h00);
        // Reset in mid-erase: the run and its action field survive
        prog(2'h1, 1'b0, 11'h000, 8'h00);
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        check({7'h00, eepromBusy}, 8'h01);
        waitIdle();
        rd(8'h3f, got); check(got, 8'h10);
        rdByte(11'h000, got); check(got, 8'hff);
        print_verdict();
    end
endmodule
